// ===== gpe_pkg.sv
// constants for the event redirection block: register map, field layout, reset values
// assumes a 32-bit avalon-mm register port and two redirectable downstream ports
package gpe_pkg;

  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          NUM_PORTS      = 2;

  // register byte offsets
  localparam logic [11:0] OFF_CONTROL    = 12'h450;
  localparam logic [11:0] OFF_STATUS     = 12'h454;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h480;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h484;

  // field positions in the control and status registers
  localparam int          POL_BIT        = 0;
  localparam int          PORT2_BIT      = 2;
  localparam int          PORT4_BIT      = 4;

  // writable bits of the control register, everything else reserved
  localparam logic [31:0] CONTROL_MASK   = 32'h0000_0015;
  localparam logic [31:0] STATUS_MASK    = 32'h0000_0014;
  localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;

  // interrupt status layout: one rise bit per port
  localparam int          IRQ_W          = 2;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage

// ===== port_route_if.sv
// carrier between the register top and one per-port event router
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface port_route_if;
  logic enable;     // redirection enable from control register
  logic alt_ok;     // shared pin is in its alternate function
  logic event_lvl;  // port has a hot-plug event pending
  logic intx_req;   // standard intx request from the port
  logic msi_req;    // standard msi request from the port
  logic pme_req;    // standard pme request from the port
  logic intx_out;   // intx request after redirection
  logic msi_out;    // msi request after redirection
  logic pme_out;    // pme request after redirection
  logic active;     // port is asserting the shared event pin

  modport ctl
  (
    output enable, alt_ok, event_lvl, intx_req, msi_req, pme_req,
    input  intx_out, msi_out, pme_out, active
  );

  modport route
  (
    input  enable, alt_ok, event_lvl, intx_req, msi_req, pme_req,
    output intx_out, msi_out, pme_out, active
  );
endinterface

// ===== event_redirect_port.sv
// one port's event router: suppresses standard notifications when redirected
// assumes requests come from logic on ref_clk, so no synchroniser is needed
`timescale 1ns/1ps
module event_redirect_port
(
  input  wire logic    ref_clk, // core clock
  input  wire logic    rst,     // synchronous reset, active high
  port_route_if.route  rt       // link to the register top
);

  logic intx_q;
  logic msi_q;
  logic pme_q;
  logic active_q;

  // a redirected port never reaches the standard notification paths
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      intx_q <= 1'b0;
      msi_q  <= 1'b0;
      pme_q  <= 1'b0;
    end
    else
    begin
      intx_q <= rt.intx_req & ~rt.enable; // [R02] [R03]
      msi_q  <= rt.msi_req  & ~rt.enable; // [R02] [R03]
      pme_q  <= rt.pme_req  & ~rt.enable; // [R02] [R03]
    end
  end

  // active only while enabled and the pin can really carry the event
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      active_q <= 1'b0;
    else
      active_q <= rt.enable & rt.event_lvl & rt.alt_ok; // [R06] [R07] [R08]
  end

  assign rt.intx_out = intx_q;
  assign rt.msi_out  = msi_q;
  assign rt.pme_out  = pme_q;
  assign rt.active   = active_q;

endmodule

// ===== general_purpose_event_signalling.sv
// general purpose event redirection for ports 2 and 4 with avalon-mm registers
// assumes port requests and the pin-mux select come from logic on ref_clk;
// the pin itself is driven out through its enable, the pad is outside
//
// Function
// [R01] one polarity bit: clear low, set high
// [R02] port 2 enabled: suppress notifications, use pin
// [R03] port 4 enabled: suppress notifications, use pin
// [R04] port 2 status shows pin being asserted
// [R05] port 4 status shows pin being asserted
// [R06] status never set while enable clear
// [R07] pin asserted only in alternate function
// [R08] pin ORs enabled ports; reserved bits zero
`timescale 1ns/1ps
module general_purpose_event_signalling
#(
  parameter int ADDR_W = gpe_pkg::ADDR_W
)
(
  input  wire logic                  ref_clk,          // core clock, 20 mhz
  input  wire logic                  rst,              // synchronous reset, active high
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]     avs_address,      // byte address
  input  wire logic                  avs_read,         // read request
  input  wire logic                  avs_write,        // write request
  input  wire logic [31:0]           avs_writedata,    // write data
  input  wire logic [3:0]            avs_byteenable,   // byte lanes
  output logic [31:0]                avs_readdata,     // read data
  output logic                       avs_waitrequest,  // stall
  // per-port hot-plug events, index 0 is port 2, index 1 is port 4
  input  wire logic [1:0]            port_event_lvl,   // event pending
  input  wire logic [1:0]            port_intx_req,    // standard intx request
  input  wire logic [1:0]            port_msi_req,     // standard msi request
  input  wire logic [1:0]            port_pme_req,     // standard pme request
  output logic [1:0]                 port_intx_out,    // intx after redirection
  output logic [1:0]                 port_msi_out,     // msi after redirection
  output logic [1:0]                 port_pme_out,     // pme after redirection
  // shared pin
  input  wire logic                  gpio7_alt_sel,    // pin muxed to alternate function
  output logic                       event_output_pin_o,  // pin level
  output logic                       event_output_pin_oe, // pin drive enable
  // interrupt
  output logic                       irq               // level interrupt
);

  // elaboration checks: this logic serves the register map and two ports only
  if (ADDR_W < 12)
  begin : g_addr_width
    $error("ADDR_W too small for the register map");
  end

  if (gpe_pkg::NUM_PORTS != 2 || gpe_pkg::IRQ_W != gpe_pkg::NUM_PORTS)
  begin : g_port_count
    $error("the routers and interrupt bits serve exactly two ports");
  end

  // only byte lane 0 is decoded, so every field has to sit in bits 7:0
  if (gpe_pkg::POL_BIT > 7 || gpe_pkg::PORT2_BIT > 7 || gpe_pkg::PORT4_BIT > 7)
  begin : g_field_lane
    $error("control and status fields must lie in byte lane 0");
  end

  if ((gpe_pkg::CONTROL_RESET & ~gpe_pkg::CONTROL_MASK) != 32'h0000_0000 ||
      (gpe_pkg::STATUS_RESET & ~gpe_pkg::STATUS_MASK) != 32'h0000_0000)
  begin : g_reset_fields
    $error("reset values may only set stored fields");
  end

  if (gpe_pkg::OFF_CONTROL[1:0] != 2'h0 || gpe_pkg::OFF_STATUS[1:0] != 2'h0 ||
      gpe_pkg::OFF_IRQ_STATUS[1:0] != 2'h0 || gpe_pkg::OFF_IRQ_MASK[1:0] != 2'h0)
  begin : g_offset_align
    $error("register offsets must be word aligned");
  end

  // ---------------------------------------------------------------- registers
  logic                      event_polarity_invert_q;
  logic                      port2_event_redirect_enable_q;
  logic                      port4_event_redirect_enable_q;
  logic [gpe_pkg::IRQ_W-1:0] irq_status_q;
  logic [gpe_pkg::IRQ_W-1:0] irq_mask_q;
  logic [1:0]                active_prev_q;
  logic [31:0]               readdata_q;
  logic                      pin_q;
  logic                      pin_oe_q;
  gpe_pkg::bus_state_t       bus_state_q;
  gpe_pkg::bus_state_t       bus_state_d;

  logic [1:0]                enable_vec;
  logic [1:0]                active_vec;
  logic [1:0]                active_rise;
  logic                      any_active;
  logic                      req;
  logic                      wr_take;
  logic                      wr_lane0;
  logic                      wr_control;
  logic                      wr_irq_status;
  logic                      wr_irq_mask;
  logic [gpe_pkg::IRQ_W-1:0] irq_clear;
  logic [1:0]                status_vec;
  logic [31:0]               control_rd;
  logic [31:0]               status_rd;
  logic [31:0]               read_mux;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
    hit = (addr == ADDR_W'(off));
  endfunction

  // ---------------------------------------------------------------- per-port routers
  // each router registers its outputs, so suppression lags an enable write by one edge and status lags the setting of an enable by one edge
  port_route_if rif [1:0] ();

  assign enable_vec = {port4_event_redirect_enable_q, port2_event_redirect_enable_q};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_port
      assign rif[gi].enable    = enable_vec[gi];
      assign rif[gi].alt_ok    = gpio7_alt_sel;
      assign rif[gi].event_lvl = port_event_lvl[gi];
      assign rif[gi].intx_req  = port_intx_req[gi];
      assign rif[gi].msi_req   = port_msi_req[gi];
      assign rif[gi].pme_req   = port_pme_req[gi];
      assign port_intx_out[gi] = rif[gi].intx_out;
      assign port_msi_out[gi]  = rif[gi].msi_out;
      assign port_pme_out[gi]  = rif[gi].pme_out;
      assign active_vec[gi]    = rif[gi].active;

      event_redirect_port u_route
      (
        .ref_clk (ref_clk),
        .rst     (rst),
        .rt      (rif[gi])
      );
    end
  endgenerate

  assign any_active = |active_vec;

  // ---------------------------------------------------------------- bus handshake
  // one wait state: the read mux is registered so the bus never sees a
  // combinational path from address to readdata
  assign req     = avs_read | avs_write;
  assign wr_take = avs_write & (bus_state_q == gpe_pkg::BUS_ACK);

  // a write lands only at the edge that ends the acknowledge cycle, and only
  // through byte lane 0, which holds every field of this block
  assign wr_lane0      = wr_take & avs_byteenable[0];
  assign wr_control    = wr_lane0 & hit(avs_address, gpe_pkg::OFF_CONTROL);
  assign wr_irq_status = wr_lane0 & hit(avs_address, gpe_pkg::OFF_IRQ_STATUS);
  assign wr_irq_mask   = wr_lane0 & hit(avs_address, gpe_pkg::OFF_IRQ_MASK);

  always_comb
  begin
    bus_state_d = bus_state_q;
    unique case (bus_state_q)
      gpe_pkg::BUS_IDLE:
      begin
        if (req)
          bus_state_d = gpe_pkg::BUS_ACK;
      end
      gpe_pkg::BUS_ACK:
      begin
        bus_state_d = gpe_pkg::BUS_IDLE;
      end
      // only a corrupted one-hot code lands here; fall back to idle
      default:
      begin
        bus_state_d = gpe_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      bus_state_q <= gpe_pkg::BUS_IDLE;
    else
      bus_state_q <= bus_state_d;
  end

  assign avs_waitrequest = req & (bus_state_q != gpe_pkg::BUS_ACK);

  // ---------------------------------------------------------------- control register
  // only byte lane 0 carries fields; reserved bits are not stored at all
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      event_polarity_invert_q       <= gpe_pkg::CONTROL_RESET[gpe_pkg::POL_BIT];
      port2_event_redirect_enable_q <= gpe_pkg::CONTROL_RESET[gpe_pkg::PORT2_BIT];
      port4_event_redirect_enable_q <= gpe_pkg::CONTROL_RESET[gpe_pkg::PORT4_BIT];
    end
    else if (wr_control)
    begin
      event_polarity_invert_q       <= avs_writedata[gpe_pkg::POL_BIT];   // [R01]
      port2_event_redirect_enable_q <= avs_writedata[gpe_pkg::PORT2_BIT]; // [R02]
      port4_event_redirect_enable_q <= avs_writedata[gpe_pkg::PORT4_BIT]; // [R03]
    end
  end

  // ---------------------------------------------------------------- interrupt
  // a port starting to assert the pin is the event; set beats a same-cycle clear
  assign active_rise = active_vec & ~active_prev_q;
  assign irq_clear   = wr_irq_status ? avs_writedata[gpe_pkg::IRQ_W-1:0] : {gpe_pkg::IRQ_W{1'b0}};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      active_prev_q <= 2'h0;
    else
      active_prev_q <= active_vec;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_status_q <= gpe_pkg::IRQ_RESET;
    else
      irq_status_q <= (irq_status_q & ~irq_clear) | active_rise;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_mask_q <= gpe_pkg::IRQ_RESET;
    else if (wr_irq_mask)
      irq_mask_q <= avs_writedata[gpe_pkg::IRQ_W-1:0];
  end

  // a level, not a pulse: it stands until software clears the status bit or the mask
  assign irq = |(irq_status_q & irq_mask_q);

  // the live enable gates status too, since the router's active flop lags a
  // disable by one edge and the bit must never read set while disabled
  assign status_vec = active_vec & enable_vec; // [R06]

  // ---------------------------------------------------------------- read path
  always_comb
  begin
    control_rd                      = 32'h0000_0000;
    control_rd[gpe_pkg::POL_BIT]    = event_polarity_invert_q;
    control_rd[gpe_pkg::PORT2_BIT]  = port2_event_redirect_enable_q;
    control_rd[gpe_pkg::PORT4_BIT]  = port4_event_redirect_enable_q;
    control_rd                      = control_rd & gpe_pkg::CONTROL_MASK; // [R08]
  end

  always_comb
  begin
    status_rd                       = gpe_pkg::STATUS_RESET;
    status_rd[gpe_pkg::PORT2_BIT]   = status_vec[0]; // [R04] [R06]
    status_rd[gpe_pkg::PORT4_BIT]   = status_vec[1]; // [R05] [R06]
    status_rd                       = status_rd & gpe_pkg::STATUS_MASK; // [R08]
  end

  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (hit(avs_address, gpe_pkg::OFF_CONTROL))
      read_mux = control_rd;
    else if (hit(avs_address, gpe_pkg::OFF_STATUS))
      read_mux = status_rd;
    else if (hit(avs_address, gpe_pkg::OFF_IRQ_STATUS))
      read_mux = 32'(irq_status_q);
    else if (hit(avs_address, gpe_pkg::OFF_IRQ_MASK))
      read_mux = 32'(irq_mask_q);
  end

  // captured on the edge that opens the acknowledge cycle; unmapped reads give zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      readdata_q <= 32'h0000_0000;
    else if (avs_read && bus_state_q == gpe_pkg::BUS_IDLE)
      readdata_q <= read_mux;
  end

  assign avs_readdata = readdata_q;

  // ---------------------------------------------------------------- event pin
  // the pin is only driven while muxed to its alternate function, so the
  // gpio block keeps the pad otherwise; idle level is the inverse of active
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pin_oe_q <= 1'b0;
    else
      pin_oe_q <= gpio7_alt_sel; // [R07]
  end

  // the reset level is the idle level of the default, active-low polarity,
  // so the pin never shows a false event while polarity is being set up
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pin_q <= 1'b1;
    else
      pin_q <= any_active ? event_polarity_invert_q : ~event_polarity_invert_q; // [R01] [R08]
  end

  assign event_output_pin_o  = pin_q;
  assign event_output_pin_oe = pin_oe_q;

endmodule

// ===== gpe_asserts.sv
// concurrent checks on the event redirection top, seen from its ports only
// assumes control writes take effect at the edge that samples waitrequest low
`timescale 1ns/1ps
module gpe_asserts
#(
  parameter int ADDR_W = gpe_pkg::ADDR_W
)
(
  input wire logic              ref_clk,             // clock
  input wire logic              rst,                 // reset
  input wire logic [ADDR_W-1:0] avs_address,         // address
  input wire logic              avs_read,            // read
  input wire logic              avs_write,           // write
  input wire logic [31:0]       avs_writedata,       // data
  input wire logic [3:0]        avs_byteenable,      // lanes
  input wire logic              avs_waitrequest,     // stall
  input wire logic [1:0]        port_event_lvl,      // events
  input wire logic [1:0]        port_intx_req,       // intx in
  input wire logic [1:0]        port_msi_req,        // msi in
  input wire logic [1:0]        port_pme_req,        // pme in
  input wire logic [1:0]        port_intx_out,       // intx out
  input wire logic [1:0]        port_msi_out,        // msi out
  input wire logic [1:0]        port_pme_out,        // pme out
  input wire logic              gpio7_alt_sel,       // mux select
  input wire logic              event_output_pin_o,  // pin level
  input wire logic              event_output_pin_oe  // pin enable
);
  logic       pol_q;
  logic [1:0] en_q;
  logic       act_any;
  // shadow of the control register, rebuilt from accepted writes
  assign act_any = |(en_q & port_event_lvl) & gpio7_alt_sel;
  always_ff @(posedge ref_clk)
    if (rst)
    begin
      pol_q <= 1'b0;
      en_q  <= 2'h0;
    end
    else if (avs_write && !avs_waitrequest && avs_address == ADDR_W'(12'h450) && avs_byteenable[0])
    begin
      pol_q <= avs_writedata[0];
      en_q  <= {avs_writedata[4], avs_writedata[2]};
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // three settled cycles cover the two-register lag to the pin
  a_pin_asserted: assert property ((act_any && $stable(pol_q))[*3] |-> event_output_pin_o == pol_q)
    else $error("pin not at asserted level");
  a_pin_idle: assert property ((!act_any && $stable(pol_q))[*3] |-> event_output_pin_o == !pol_q)
    else $error("pin not at idle level");
  a_intx_gated: assert property (!$past(rst) |-> port_intx_out == ($past(port_intx_req) & ~$past(en_q)))
    else $error("intx not gated by enable");
  a_msi_gated: assert property (!$past(rst) |-> port_msi_out == ($past(port_msi_req) & ~$past(en_q)))
    else $error("msi not gated by enable");
  a_pme_gated: assert property (!$past(rst) |-> port_pme_out == ($past(port_pme_req) & ~$past(en_q)))
    else $error("pme not gated by enable");
  a_oe_follows_mux: assert property (!$past(rst) |-> event_output_pin_oe == $past(gpio7_alt_sel))
    else $error("pin enable not following mux");
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_bus_ack_waited: assert property ((avs_read || avs_write) && !avs_waitrequest |-> $past(avs_waitrequest))
    else $error("bus answer without wait state");
  c_active_low: cover property (act_any && !pol_q ##3 !event_output_pin_o);
  c_active_high: cover property (act_any && pol_q ##3 event_output_pin_o);
  c_no_alt: cover property (!gpio7_alt_sel && en_q != 2'h0 && port_event_lvl != 2'h0);
endmodule

bind general_purpose_event_signalling gpe_asserts #(.ADDR_W(ADDR_W)) chk
(
  .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .port_event_lvl(port_event_lvl), .port_intx_req(port_intx_req), .port_msi_req(port_msi_req),
  .port_pme_req(port_pme_req), .port_intx_out(port_intx_out), .port_msi_out(port_msi_out),
  .port_pme_out(port_pme_out), .gpio7_alt_sel(gpio7_alt_sel), .event_output_pin_o(event_output_pin_o),
  .event_output_pin_oe(event_output_pin_oe)
);

// ===== event_pin_monitor.sv
// system logic watching the shared event pin
// assumes a board pull-up holds the wire high when the block does not drive it
`timescale 1ns/1ps
module event_pin_monitor
(
  input  wire logic ref_clk,     // clock
  input  wire logic pin_o,       // block level
  input  wire logic pin_oe,      // block enable
  input  wire logic active_high, // expected polarity
  output logic      pin_level,   // wire level
  output logic      event_seen   // event flag
);
  assign pin_level = pin_oe ? pin_o : 1'b1;
  always_ff @(posedge ref_clk)
    event_seen <= (pin_level == active_high);
endmodule

// ===== general_purpose_event_signalling_bench.sv
// self-checking bench for the event redirection block
// assumes one clock and an avalon-mm register port with one wait state
`timescale 1ns/1ps
module general_purpose_event_signalling_bench;
  logic        ref_clk, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, alt = 1'b0, pol_exp = 1'b0;
  logic [11:0] avs_address = 12'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        avs_waitrequest, pin_o, pin_oe, irq, pin_level, event_seen;
  logic [1:0]  lvl = 2'h0, intx = 2'h0, msi = 2'h0, pme = 2'h0, intx_o, msi_o, pme_o;
  logic [3:0]  be = 4'hf;
  int          miscompares = 0, tests_run = 0, p;

  general_purpose_event_signalling dut
  (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_event_lvl(lvl), .port_intx_req(intx), .port_msi_req(msi),
    .port_pme_req(pme), .port_intx_out(intx_o), .port_msi_out(msi_o), .port_pme_out(pme_o),
    .gpio7_alt_sel(alt), .event_output_pin_o(pin_o), .event_output_pin_oe(pin_oe), .irq(irq)
  );
  event_pin_monitor mon
  (
    .ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe), .active_high(pol_exp),
    .pin_level(pin_level), .event_seen(event_seen)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one access; released after the accepting edge, then one idle edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      final_report();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  initial
  begin
    tick(12);
    rst <= 1'b0;
    tick(1);
    rdchk("control reset", 12'h450, 32'h0);
    rdchk("status reset", 12'h454, 32'h0);
    check("pin reset", {pin_oe, pin_o}, 32'h1);
    bus(1'b1, 12'h450, 32'hffff_ffff);
    rdchk("control reserved", 12'h450, 32'h15);
    bus(1'b1, 12'h454, 32'hffff_ffff);
    rdchk("status read only", 12'h454, 32'h0);
    rdchk("unmapped", 12'h500, 32'h0);
    bus(1'b1, 12'h450, 32'h0);
    be <= 4'he;
    bus(1'b1, 12'h450, 32'hffff_ffff);
    be <= 4'hf;
    rdchk("control lane 0 off", 12'h450, 32'h0);
    $display("test registers done");
    for (p = 0; p < 2; p++)
    begin
      alt  <= 1'b1;
      lvl  <= 2'h1 << p;
      intx <= 2'h3;
      msi  <= 2'h3;
      pme  <= 2'h3;
      tick(3);
      rdchk("status disabled", 12'h454, 32'h0);
      check("notify passed", {intx_o, msi_o, pme_o}, 32'h3f);
      check("pin idle", pin_o, 32'h1);
      bus(1'b1, 12'h450, 32'h4 << (2 * p));
      tick(3);
      rdchk("status enabled", 12'h454, 32'h4 << (2 * p));
      check("notify gated", {intx_o, msi_o, pme_o}, {3{2'h2 >> p}});
      check("pin active low", {pin_oe, pin_o, event_seen}, 32'h5);
      rdchk("irq status", 12'h480, 32'h1 << p);
      check("irq masked", irq, 32'h0);
      bus(1'b1, 12'h484, 32'h3);
      check("irq raised", irq, 32'h1);
      bus(1'b1, 12'h480, 32'h3);
      check("irq cleared", irq, 32'h0);
      bus(1'b1, 12'h484, 32'h0);
      pol_exp <= 1'b1;
      bus(1'b1, 12'h450, (32'h4 << (2 * p)) | 32'h1);
      tick(3);
      check("pin active high", {pin_oe, pin_o, event_seen}, 32'h7);
      alt <= 1'b0;
      tick(3);
      rdchk("status no alt", 12'h454, 32'h0);
      check("pin released", {pin_oe, pin_level}, 32'h1);
      lvl     <= 2'h0;
      pol_exp <= 1'b0;
      bus(1'b1, 12'h450, 32'h0);
      $display("test port %0d done", p);
    end
    final_report();
  end
endmodule
